// ==== rtl/root_hub_pkg.sv ====
// Purpose: shared constants and types for the root hub port status block
// Assumes: 10 MHz clock, 32-bit Avalon-MM slave, byte addresses
// Notes:   offsets are byte addresses of word-aligned registers
package root_hub_pkg;
	localparam int          NUM_PORTS = 2;
	localparam int          CLK_HZ    = 10_000_000;
	localparam int          ADDR_W    = 8;
	// register byte offsets
	localparam logic [7:0]  OFS_PORT0      = 8'h54;
	localparam logic [7:0]  OFS_PORT1      = 8'h58;
	localparam logic [7:0]  OFS_HUB_CFG    = 8'h60;
	localparam logic [7:0]  OFS_GLOBAL_CMD = 8'h64;
	localparam logic [7:0]  OFS_IRQ_STAT   = 8'h70;
	localparam logic [7:0]  OFS_IRQ_CLR    = 8'h74;
	localparam logic [7:0]  OFS_IRQ_EN     = 8'h78;
	// port register bit positions
	localparam int BIT_RESET_DONE_CHG = 20;
	localparam int BIT_OC_CHG         = 19;
	localparam int BIT_RESUME_CHG     = 18;
	localparam int BIT_ENABLE_CHG     = 17;
	localparam int BIT_CONNECT_CHG    = 16;
	localparam int BIT_SPEED_CPP      = 9;
	localparam int BIT_POWER_SPP      = 8;
	localparam int BIT_RESET_SPR      = 4;
	localparam int BIT_OC_CSS         = 3;
	localparam int BIT_SUSP_SPS       = 2;
	localparam int BIT_ENABLE_SPE     = 1;
	localparam int BIT_CONN_CPE       = 0;
	// hub configuration register fields
	localparam int CFG_PER_PORT_SW   = 0;
	localparam int CFG_NO_SWITCHING  = 1;
	localparam int CFG_NO_PROTECT    = 2;
	localparam int CFG_PER_PORT_OC   = 3;
	localparam int CFG_MASK_LSB      = 4;
	localparam int CFG_REMOVE_LSB    = 6;
	localparam int CFG_FSTATE_LSB    = 8;
	localparam logic [9:0]  CFG_RESET = 10'h009;
	localparam logic [9:0]  CFG_MASK  = 10'h3FF;
	// global command register fields
	localparam int GCMD_SET_POWER = 0;
	localparam int GCMD_CLR_POWER = 1;
	// operational functional state
	localparam logic [1:0]  FSTATE_OPERATIONAL = 2'h1;
	// timing
	localparam int RESET_TIME_MS  = 10;
	localparam int RESUME_TIME_MS = 20;
	localparam int RESET_CYCLES   = RESET_TIME_MS * (CLK_HZ / 1000);
	localparam int RESUME_CYCLES  = RESUME_TIME_MS * (CLK_HZ / 1000);
	localparam int CNT_W          = 18;
	localparam int IRQ_W          = 5 * NUM_PORTS;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'b001,
		PH_RESET  = 3'b010,
		PH_RESUME = 3'b100
	} port_phase_t;

	// readable state of one port, in register order
	typedef struct packed {
		logic reset_done_change;
		logic overcurrent_change;
		logic resume_done_change;
		logic enable_change;
		logic connect_change;
		logic low_speed_attached;
		logic power_on_status;
		logic reset_active_status;
		logic overcurrent_status;
		logic suspended_status;
		logic enabled_status;
		logic connected_status;
	} port_state_t;
endpackage

// ==== rtl/usb_root_hub_port_status.sv ====
// Purpose: per-port status and control of a two-port USB root hub
// Assumes: single 10 MHz clock, synchronous active-high reset,
//          device pins asynchronous to clk
// Notes:   Avalon-MM slave with one wait state on every access
`timescale 1ns/1ps
`default_nettype none
module usb_root_hub_port_status #(
	parameter int RESET_CNT  = root_hub_pkg::RESET_CYCLES,
	parameter int RESUME_CNT = root_hub_pkg::RESUME_CYCLES
) (
	input  wire logic                                clk,
	input  wire logic                                sys_rst,
	input  wire logic [root_hub_pkg::ADDR_W-1:0]     address,
	input  wire logic                                read,
	input  wire logic                                write,
	input  wire logic [31:0]                         writedata,
	input  wire logic [3:0]                          byteenable,
	output logic      [31:0]                         readdata,
	output logic                                     waitrequest,
	input  wire logic [root_hub_pkg::NUM_PORTS-1:0]  dev_connect,
	input  wire logic [root_hub_pkg::NUM_PORTS-1:0]  dev_low_speed,
	input  wire logic [root_hub_pkg::NUM_PORTS-1:0]  overcurrent_pin,
	input  wire logic [root_hub_pkg::NUM_PORTS-1:0]  bubble_err,
	output logic      [root_hub_pkg::NUM_PORTS-1:0]  port_power,
	output logic      [root_hub_pkg::NUM_PORTS-1:0]  port_reset_drive,
	output logic      [root_hub_pkg::NUM_PORTS-1:0]  port_suspend,
	output logic      [root_hub_pkg::NUM_PORTS-1:0]  port_enable,
	output logic                                     irq
);
	import root_hub_pkg::*;

	// bus handshake: one wait state, answer on the second cycle
	logic             ack_ff;
	logic [31:0]      rdata_ff;
	logic [9:0]       cfg_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_en_ff;
	wire              req      = read | write;
	wire              take_wr  = write & ack_ff;
	wire              take_rd  = read & ~ack_ff;
	wire [31:0]       be_mask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};
	wire [31:0]       wd       = writedata & be_mask; // lanes off act as 0
	wire              hit_cfg  = address == OFS_HUB_CFG;
	wire              hit_gcmd = address == OFS_GLOBAL_CMD;
	wire              hit_ist  = address == OFS_IRQ_STAT;
	wire              hit_iclr = address == OFS_IRQ_CLR;
	wire              hit_ien  = address == OFS_IRQ_EN;
	// a held request sees waitrequest fall in its second cycle, so the
	// master never has to assume a fixed latency
	assign waitrequest = req & ~ack_ff;
	assign readdata    = rdata_ff;
	assign irq         = |(irq_stat_ff & irq_en_ff);

	// ack toggles, so back-to-back requests each get one wait state
	always_ff @(posedge clk) begin
		if (sys_rst)
			ack_ff <= 1'b0;
		else
			ack_ff <= req & ~ack_ff;
	end

	// hub configuration fields, taken from the configuration register
	wire       per_port_switching = cfg_ff[CFG_PER_PORT_SW];
	wire       no_switching       = cfg_ff[CFG_NO_SWITCHING];
	wire       no_protection      = cfg_ff[CFG_NO_PROTECT];
	wire       per_port_overcurrent = cfg_ff[CFG_PER_PORT_OC];
	wire [1:0] power_mask_field   = cfg_ff[CFG_MASK_LSB +: 2];
	wire [1:0] removable_field    = cfg_ff[CFG_REMOVE_LSB +: 2];
	wire [1:0] functional_state   = cfg_ff[CFG_FSTATE_LSB +: 2];
	wire       fs_operational = functional_state == FSTATE_OPERATIONAL;
	wire       set_global_power = take_wr & hit_gcmd & wd[GCMD_SET_POWER];
	wire       clear_global_power = take_wr & hit_gcmd & wd[GCMD_CLR_POWER];
	wire       oc_report = ~no_protection & per_port_overcurrent;

	// configuration and interrupt enable registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_ff    <= CFG_RESET;
			irq_en_ff <= '0;
		end else if (take_wr) begin
			if (hit_cfg)
				cfg_ff <= (cfg_ff & ~be_mask[9:0]) | (wd[9:0] & CFG_MASK);
			if (hit_ien)
				irq_en_ff <= (irq_en_ff & ~be_mask[IRQ_W-1:0])
					| wd[IRQ_W-1:0];
		end
	end

	port_state_t          pst [NUM_PORTS];
	logic [IRQ_W-1:0]     irq_ev;
	logic [NUM_PORTS-1:0] hit_port;

	// sticky interrupt status; a new event beats a clear in the same cycle
	wire [IRQ_W-1:0] irq_clr = (take_wr & hit_iclr) ? wd[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~irq_clr) | irq_ev;
	always_ff @(posedge clk) begin
		if (sys_rst)
			irq_stat_ff <= '0;
		else
			irq_stat_ff <= nxt_irq_stat;
	end

	// read mux; unmapped and write-only words read as zero
	// reads have no side effect; change flags clear by write-one, resume-done also when reset-done newly sets
	logic [31:0] rmux;
	always_comb begin
		rmux = ZERO_WORD;
		if (hit_port[0])
			rmux = {11'h000, pst[0][11:7], 6'h00, pst[0][6:5], 3'h0,
				pst[0][4:0]};
		else if (hit_port[1])
			rmux = {11'h000, pst[1][11:7], 6'h00, pst[1][6:5], 3'h0,
				pst[1][4:0]};
		else if (hit_cfg)
			rmux = {22'h000000, cfg_ff};
		else if (hit_ist)
			rmux = {{(32-IRQ_W){1'b0}}, irq_stat_ff};
		else if (hit_ien)
			rmux = {{(32-IRQ_W){1'b0}}, irq_en_ff};
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			rdata_ff <= ZERO_WORD;
		else if (take_rd)
			rdata_ff <= rmux;
	end

	// one identical copy of the port logic per downstream port
	genvar p;
	generate
		for (p = 0; p < NUM_PORTS; p++) begin : g_port
			logic [2:0]  con_s_ff, ls_s_ff, oc_s_ff, bub_s_ff;
			logic        con_f_ff, ls_f_ff, oc_f_ff, bub_f_ff;
			logic        ccs_ff, en_ff, susp_ff, pwr_ff, oc_ff, ls_ff;
			logic        rdc_ff, occ_ff, rsc_ff, enc_ff, csc_ff;
			logic        bub_d_ff;
			logic [CNT_W-1:0] cnt_ff;
			port_phase_t phase_ff;

			// three-stage synchronisers; a change counts when 2 and 3 agree
			// stage 1 feeds only stage 2, so metastability stays contained
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					con_s_ff <= 3'h0;
					ls_s_ff  <= 3'h0;
					oc_s_ff  <= 3'h0;
					bub_s_ff <= 3'h0;
					con_f_ff <= 1'b0;
					ls_f_ff  <= 1'b0;
					oc_f_ff  <= 1'b0;
					bub_f_ff <= 1'b0;
				end else begin
					con_s_ff <= {con_s_ff[1:0], dev_connect[p]};
					ls_s_ff  <= {ls_s_ff[1:0], dev_low_speed[p]};
					oc_s_ff  <= {oc_s_ff[1:0], overcurrent_pin[p]};
					bub_s_ff <= {bub_s_ff[1:0], bubble_err[p]};
					if (con_s_ff[1] == con_s_ff[2])
						con_f_ff <= con_s_ff[2];
					if (ls_s_ff[1] == ls_s_ff[2])
						ls_f_ff <= ls_s_ff[2];
					if (oc_s_ff[1] == oc_s_ff[2])
						oc_f_ff <= oc_s_ff[2];
					if (bub_s_ff[1] == bub_s_ff[2])
						bub_f_ff <= bub_s_ff[2];
				end
			end

			// write decode of this port's word and its command bits
			wire hit = address == (p == 0 ? OFS_PORT0 : OFS_PORT1);
			wire wr  = take_wr & hit;
			wire c_rdc  = wr & wd[BIT_RESET_DONE_CHG];
			wire c_occ  = wr & wd[BIT_OC_CHG];
			wire c_rsc  = wr & wd[BIT_RESUME_CHG];
			wire c_enc  = wr & wd[BIT_ENABLE_CHG];
			wire c_csc  = wr & wd[BIT_CONNECT_CHG];
			wire c_cpp  = wr & wd[BIT_SPEED_CPP];  // write meaning
			wire c_spp  = wr & wd[BIT_POWER_SPP];
			wire c_spr  = wr & wd[BIT_RESET_SPR];
			wire c_css  = wr & wd[BIT_OC_CSS];
			wire c_sps  = wr & wd[BIT_SUSP_SPS];
			wire c_spe  = wr & wd[BIT_ENABLE_SPE];
			wire c_cpe  = wr & wd[BIT_CONN_CPE];   // write meaning
			assign hit_port[p] = hit;

			// overcurrent status and its rising edge
			wire nxt_oc   = oc_report & oc_f_ff;
			wire oc_event = nxt_oc & ~oc_ff;
			wire bubble   = bub_f_ff & ~bub_d_ff & en_ff;
			wire masked   = power_mask_field[p];
			wire pwr_on   = (~per_port_switching & set_global_power)
				| (per_port_switching & ~masked & set_global_power)
				| (per_port_switching & masked & c_spp);
			wire pwr_off  = (~per_port_switching & clear_global_power)
				| (per_port_switching & ~masked & clear_global_power)
				| (per_port_switching & masked & c_cpp)
				| oc_event;
			// no_switching beats every clear: power stays on while running
			wire nxt_pwr  = no_switching | ((pwr_ff | pwr_on) & ~pwr_off);
			wire pwr_drop = pwr_ff & ~nxt_pwr;
			wire nxt_ccs  = con_f_ff & nxt_pwr;
			wire disc     = ccs_ff & ~nxt_ccs;

			// reset and resume timing share one counter
			wire cnt_done = cnt_ff == CNT_W'(1);
			wire rst_done = phase_ff == PH_RESET & cnt_done;
			wire rsm_done = phase_ff == PH_RESUME & cnt_done;
			wire rst_end  = rst_done & fs_operational;
			wire start_rst = c_spr & ccs_ff & phase_ff != PH_RESET;
			wire start_rsm = c_css & susp_ff & phase_ff == PH_IDLE;
			port_phase_t nxt_phase;
			logic [CNT_W-1:0] nxt_cnt;
			// a reset that times out outside the operational state stays
			// asserted; parking the counter at zero sets its flag only once
			always_comb begin
				nxt_phase = phase_ff;
				nxt_cnt   = (cnt_ff > CNT_W'(1)) ? cnt_ff - CNT_W'(1) : cnt_ff;
				case (phase_ff)
					PH_IDLE: begin
						if (start_rst) begin
							nxt_phase = PH_RESET;
							nxt_cnt   = CNT_W'(RESET_CNT);
						end else if (start_rsm) begin
							nxt_phase = PH_RESUME;
							nxt_cnt   = CNT_W'(RESUME_CNT);
						end
					end
					PH_RESET: begin
						if (rst_end | pwr_drop)
							nxt_phase = PH_IDLE;
						else if (rst_done)
							nxt_cnt   = '0;
					end
					PH_RESUME: begin
						if (start_rst) begin
							nxt_phase = PH_RESET;
							nxt_cnt   = CNT_W'(RESET_CNT);
						end else if (rsm_done | pwr_drop)
							nxt_phase = PH_IDLE;
					end
					default: nxt_phase = PH_IDLE;
				endcase
			end

			// port state bits, cleared by the hardware reset and loaded every cycle
			wire nxt_susp = (susp_ff | (c_sps & ccs_ff))
				& ~(pwr_drop & (rsc_ff | rsm_done))
				& ~rst_end & ~rsm_done;
			wire nxt_en = (en_ff | (c_spe & ccs_ff) | rst_done
				| rsm_done)
				& ~c_cpe & ~oc_event & ~disc & ~bubble & nxt_ccs;
			// change flags: a set wins over the write-one clear
			// resume-done also drops when reset-done newly sets
			wire nxt_rdc = (rdc_ff & ~c_rdc) | rst_done;
			wire nxt_occ = (occ_ff & ~c_occ) | (nxt_oc ^ oc_ff);
			wire nxt_rsc = ((rsc_ff & ~c_rsc) & ~(rst_done & ~rdc_ff))
				| rsm_done;
			wire nxt_enc = (enc_ff & ~c_enc) | oc_event | disc
				| bubble;
			wire csc_set = (~ccs_ff & (c_spr | c_spe | c_sps))
				| (removable_field[p] & (nxt_ccs ^ ccs_ff));
			wire nxt_csc = (csc_ff & ~c_csc) | csc_set;

			always_ff @(posedge clk) begin
				if (sys_rst) begin
					phase_ff <= PH_IDLE;
					cnt_ff   <= '0;
					pwr_ff   <= 1'b0;
					ccs_ff   <= 1'b0;
					en_ff    <= 1'b0;
					susp_ff  <= 1'b0;
					oc_ff    <= 1'b0;
					ls_ff    <= 1'b0;
					bub_d_ff <= 1'b0;
					rdc_ff   <= 1'b0;
					occ_ff   <= 1'b0;
					rsc_ff   <= 1'b0;
					enc_ff   <= 1'b0;
					csc_ff   <= 1'b0;
				end else begin
					phase_ff <= nxt_phase;
					cnt_ff   <= nxt_cnt;
					pwr_ff   <= nxt_pwr;
					ccs_ff   <= nxt_ccs;
					en_ff    <= nxt_en;
					susp_ff  <= nxt_susp;
					oc_ff    <= nxt_oc;
					ls_ff    <= nxt_ccs & ls_f_ff;
					bub_d_ff <= bub_f_ff;
					rdc_ff   <= nxt_rdc;
					occ_ff   <= nxt_occ;
					rsc_ff   <= nxt_rsc;
					enc_ff   <= nxt_enc;
					csc_ff   <= nxt_csc;
				end
			end

			// interrupt events: rising edges of the five change flags
			assign irq_ev[5*p +: 5] = {nxt_rdc & ~rdc_ff, nxt_occ & ~occ_ff,
				nxt_rsc & ~rsc_ff, nxt_enc & ~enc_ff, nxt_csc & ~csc_ff};

			assign pst[p] = '{reset_done_change:   rdc_ff,
				overcurrent_change:  occ_ff,
				resume_done_change:  rsc_ff,
				enable_change:       enc_ff,
				connect_change:      csc_ff,
				low_speed_attached:  ls_ff,
				power_on_status:     pwr_ff,
				reset_active_status: phase_ff == PH_RESET,
				overcurrent_status:  oc_ff,
				suspended_status:    susp_ff,
				enabled_status:      en_ff,
				connected_status:    ccs_ff};
			assign port_power[p]       = pwr_ff;
			assign port_reset_drive[p] = phase_ff == PH_RESET;
			assign port_suspend[p]     = susp_ff;
			assign port_enable[p]      = en_ff;
		end
	endgenerate
endmodule
`default_nettype wire

// ==== testbench/port_status_chk.sv ====
// Purpose: concurrent checks on the root hub port block pins
// Assumes: per-port overcurrent mode kept, port 0 watched
// Notes:   reset end bound follows the bound parameter, hold check fixed at 6 cycles
`timescale 1ns/1ps
`default_nettype none
module port_status_chk #(
	parameter int RESET_CNT  = 8,
	parameter int RESUME_CNT = 12
) (
	input wire logic                               clk,
	input wire logic                               sys_rst,
	input wire logic [root_hub_pkg::ADDR_W-1:0]    address,
	input wire logic                               read,
	input wire logic                               write,
	input wire logic [31:0]                        writedata,
	input wire logic [3:0]                         byteenable,
	input wire logic [31:0]                        readdata,
	input wire logic                               waitrequest,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] dev_connect,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] dev_low_speed,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] overcurrent_pin,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] bubble_err,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] port_power,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] port_reset_drive,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] port_suspend,
	input wire logic [root_hub_pkg::NUM_PORTS-1:0] port_enable,
	input wire logic                               irq
);
	import root_hub_pkg::*;
	// slack covers the write cycle and the done edge
	localparam int RST_MAX = RESET_CNT + 4;
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// a bus access: request held, then its answer
	sequence req_s;
		(read || write) && waitrequest;
	endsequence
	sequence ack_s;
		(read || write) && !waitrequest;
	endsequence
	sequence port_rd_s;
		ack_s ##0 (read && (address == OFS_PORT0 || address == OFS_PORT1));
	endsequence
	one_wait_a:
		assert property (req_s |=> ack_s)
		else $error("bus answer not after one wait state");
	rsvd_zero_a:
		assert property (port_rd_s |-> readdata[31:21] == 11'h000 &&
			readdata[15:10] == 6'h00 && readdata[7:5] == 3'h0)
		else $error("reserved port bits read nonzero");
	off_ends_rst_a:
		assert property ($fell(port_power[0]) |-> ##[0:2] !port_reset_drive[0])
		else $error("reset kept after power off");
	off_ends_susp_a:
		assert property ($fell(port_power[0]) |-> ##[0:2] !port_suspend[0])
		else $error("suspend kept after power off");
	oc_power_a:
		assert property ($rose(overcurrent_pin[0]) |-> ##[2:8] !port_power[0])
		else $error("overcurrent left power on");
	oc_disable_a:
		assert property ($rose(overcurrent_pin[0]) |-> ##[2:8] !port_enable[0])
		else $error("overcurrent left port enabled");
	rst_hold_a:
		assert property ($rose(port_reset_drive[0]) |=> port_reset_drive[0][*6])
		else $error("port reset ended early");
	rst_end_a:
		assert property ($rose(port_reset_drive[0]) |->
			##[1:RST_MAX] !port_reset_drive[0])
		else $error("port reset did not end");
	rst_enable_a:
		assert property (($fell(port_reset_drive[0]) && port_power[0]) |->
			##[0:1] port_enable[0])
		else $error("port not enabled at reset end");
endmodule
bind usb_root_hub_port_status port_status_chk #(
	.RESET_CNT(RESET_CNT), .RESUME_CNT(RESUME_CNT)) chk (
	.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
	.write(write), .writedata(writedata), .byteenable(byteenable),
	.readdata(readdata), .waitrequest(waitrequest),
	.dev_connect(dev_connect), .dev_low_speed(dev_low_speed),
	.overcurrent_pin(overcurrent_pin), .bubble_err(bubble_err),
	.port_power(port_power), .port_reset_drive(port_reset_drive),
	.port_suspend(port_suspend), .port_enable(port_enable), .irq(irq));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Purpose: register level test of the root hub port block
// Assumes: short reset and resume counts of 8 and 12 cycles
// Notes:   port 1 masked late to reach per-port power commands
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import root_hub_pkg::*;
	logic        clk, sys_rst, read, write, irq, waitrequest;
	logic [7:0]  address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable;
	logic [1:0]  dev_connect, dev_low_speed, overcurrent_pin, bubble_err;
	logic [1:0]  port_power, port_reset_drive, port_suspend, port_enable;
	logic [1:0]  plug, slow, fault, bubble;
	int          error_cnt, checked;
	usb_root_hub_port_status #(.RESET_CNT(8), .RESUME_CNT(12)) uut (
		.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.dev_connect(dev_connect), .dev_low_speed(dev_low_speed),
		.overcurrent_pin(overcurrent_pin), .bubble_err(bubble_err),
		.port_power(port_power), .port_reset_drive(port_reset_drive),
		.port_suspend(port_suspend), .port_enable(port_enable), .irq(irq));
	usb_port_dev dev (.power(port_power), .plug(plug), .slow(slow),
		.fault(fault), .bubble(bubble), .dev_connect(dev_connect),
		.dev_low_speed(dev_low_speed), .overcurrent_pin(overcurrent_pin),
		.bubble_err(bubble_err));
	always #50 clk = ~clk;
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// hold the request until a rising edge samples waitrequest low;
	// read data are taken at that edge, the watchdog bounds the wait
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check($sformatf("register %h", a), q, exp);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// whole run is a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		report_and_stop();
	end
	initial begin
		clk = 0; sys_rst = 1; read = 0; write = 0; address = 8'h00;
		writedata = 32'h0; byteenable = 4'hF; plug = 0; slow = 0;
		fault = 0; bubble = 0; error_cnt = 0; checked = 0;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rd(OFS_PORT0, 32'h0);
		rd(8'hF0, 32'h0);
		wr(OFS_HUB_CFG, 32'h109);
		wr(OFS_GLOBAL_CMD, 32'h1);
		rd(OFS_PORT1, 32'h100);
		wr(OFS_PORT1, 32'h2);
		rd(OFS_PORT1, 32'h10100);
		wr(OFS_PORT1, 32'h10000);
		rd(OFS_PORT1, 32'h100);
		$display("test power and connect change done");
		plug <= 2'h1;
		slow <= 2'h1;
		idle(10);
		rd(OFS_PORT0, 32'h301);
		wr(OFS_PORT0, 32'h10);
		rd(OFS_PORT0, 32'h311);
		idle(20);
		rd(OFS_PORT0, 32'h100303);
		check("irq", irq, 1'b0);
		wr(OFS_IRQ_EN, 32'h10);
		idle(2);
		check("irq", irq, 1'b1);
		wr(OFS_IRQ_CLR, 32'h3FF);
		idle(2);
		check("irq", irq, 1'b0);
		rd(OFS_IRQ_STAT, 32'h0);
		$display("test reset done");
		wr(OFS_PORT0, 32'h100004);
		rd(OFS_PORT0, 32'h307);
		wr(OFS_PORT0, 32'h8);
		idle(20);
		rd(OFS_PORT0, 32'h40303);
		wr(OFS_PORT0, 32'h10);
		idle(20);
		rd(OFS_PORT0, 32'h100303);
		wr(OFS_PORT0, 32'h100001);
		rd(OFS_PORT0, 32'h301);
		$display("test suspend and resume done");
		wr(OFS_PORT0, 32'h2);
		bubble <= 2'h1;
		idle(10);
		rd(OFS_PORT0, 32'h20301);
		bubble <= 2'h0;
		wr(OFS_PORT0, 32'h20002);
		fault <= 2'h1;
		idle(10);
		check("port_power", port_power, 2'h2);
		rd(OFS_PORT0, 32'hA0008);
		fault <= 2'h0;
		idle(10);
		rd(OFS_PORT0, 32'hA0000);
		wr(OFS_PORT0, 32'hA0000);
		rd(OFS_PORT0, 32'h0);
		$display("test faults done");
		wr(OFS_HUB_CFG, 32'h129);
		wr(OFS_GLOBAL_CMD, 32'h1);
		idle(2);
		check("port_power", port_power, 2'h3);
		wr(OFS_GLOBAL_CMD, 32'h2);
		idle(2);
		check("port_power", port_power, 2'h2);
		wr(OFS_PORT1, 32'h200);
		rd(OFS_PORT1, 32'h0);
		wr(OFS_PORT1, 32'h100);
		rd(OFS_PORT1, 32'h100);
		rd(OFS_HUB_CFG, 32'h129);
		$display("test masked power done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ==== testbench/usb_port_dev.sv ====
// Purpose: downstream devices seen on the two root hub ports
// Assumes: a device shows itself only while its port is powered
// Notes:   plug, speed, fault and bubble are commanded by the bench
`timescale 1ns/1ps
`default_nettype none
module usb_port_dev (
	input  wire logic [1:0] power,
	input  wire logic [1:0] plug,
	input  wire logic [1:0] slow,
	input  wire logic [1:0] fault,
	input  wire logic [1:0] bubble,
	output logic      [1:0] dev_connect,
	output logic      [1:0] dev_low_speed,
	output logic      [1:0] overcurrent_pin,
	output logic      [1:0] bubble_err
);
	// unpowered device cannot pull its line, the pull-down reads 0
	assign dev_connect     = plug & power;
	assign dev_low_speed   = slow & plug & power;
	assign overcurrent_pin = fault;
	assign bubble_err      = bubble;
endmodule
`default_nettype wire
